// ---- hdl/pic_pkg.sv ----
// constants and carrier types for the cascaded priority interrupt controller
// assumes a single 10 MHz clock and host strobes synchronous to it
package pic_pkg;
   localparam int unsigned NUM_LEVELS = 8;
   localparam int unsigned CAS_WIDTH = 3;
   localparam int unsigned CLOCK_NS = 100;
   localparam int unsigned REQ_LOW_NS = 100;
   localparam int unsigned REQ_LOW_CYCLES =
      ((REQ_LOW_NS + CLOCK_NS - 1) / CLOCK_NS) < 1 ? 1 : ((REQ_LOW_NS + CLOCK_NS - 1) / CLOCK_NS);
   // mode byte fields (register select low)
   localparam int unsigned INIT_FLAG_BIT = 4;
   localparam int unsigned LEVEL_MODE_BIT = 3;
   localparam int unsigned SINGLE_BIT = 1;
   localparam int unsigned NEED_FOURTH_BIT = 0;
   localparam int unsigned CMD3_BIT = 3;
   localparam int unsigned EOI_BIT = 5;
   localparam int unsigned SPECIFIC_BIT = 6;
   localparam int unsigned READ_SEL_EN_BIT = 1;
   localparam int unsigned READ_SEL_IS_BIT = 0;
   // fourth init byte fields
   localparam int unsigned WIDE_CPU_BIT = 0;
   localparam int unsigned AUTO_EOI_BIT = 1;
   localparam int unsigned BUF_MASTER_BIT = 2;
   localparam int unsigned BUFFERED_BIT = 3;
   localparam logic [7:0] CALL_OPCODE = 8'h00_CD;
   localparam logic [7:0] MASK_RESET = 8'h00_00;

   typedef enum logic [1:0] {
      INIT_IDLE = 2'b00,
      INIT_VEC = 2'b01,
      INIT_CAS = 2'b11,
      INIT_MODE = 2'b10
   } init_state_type;

   // host bus: active-low strobes, register select bit and write data
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic ack_n;
      logic register_select_bit;
      logic [7:0] wdata;
   } host_bus_type;

   // configuration gathered by the init sequence
   typedef struct packed {
      logic level_mode;
      logic single;
      logic need_fourth;
      logic wide_cpu;
      logic auto_eoi;
      logic buffered;
      logic buf_master;
      logic [4:0] vec_base;
      logic [7:0] third_init_byte;
   } config_type;
endpackage

// ---- hdl/req_latch.sv ----
// per-input request latch: edge or level sensing
// assumes request inputs already synchronised to clock
module req_latch #(
   parameter int unsigned N = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic level_mode,
   input wire logic [N-1:0] request_inputs,
   input wire logic [N-1:0] clear,
   input wire logic init_clear,
   output logic [N-1:0] request_register
);
   typedef struct packed {
      logic [N-1:0] armed;
      logic [N-1:0] req;
   } st_type;
   st_type s_q, s_d;

   // edge detect needs the line low first; level mode follows the line
   always_comb begin
      s_d = s_q;
      for (int i = 0; i < N; i++) begin
         if (!request_inputs[i]) s_d.armed[i] = 1'b1;
         if (init_clear) begin
            s_d.req[i] = 1'b0;
            s_d.armed[i] = 1'b0;
         end else if (level_mode) begin
            s_d.req[i] = request_inputs[i] & ~clear[i];
         end else if (request_inputs[i] && s_q.armed[i]) begin
            s_d.req[i] = 1'b1;
            s_d.armed[i] = 1'b0;
         end else if (clear[i] || !request_inputs[i]) begin
            s_d.req[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) s_q <= '0;
      else s_q <= s_d;
   end

   assign request_register = s_q.req;

   edge_sets_a: assert property (@(posedge clock) disable iff (!rst_n)
      (!level_mode && !init_clear && request_inputs[0] && s_q.armed[0])
      |=> request_register[0]) else $error("edge not registered");
endmodule // req_latch

// ---- hdl/prio_pick.sv ----
// fixed priority resolver, level 0 highest
// assumes inputs are already masked
module prio_pick #(
   parameter int unsigned N = 8,
   parameter int unsigned W = 3
) (
   input wire logic [N-1:0] vec,
   output logic hit,
   output logic [W-1:0] idx
);
   // lowest set bit wins
   always_comb begin
      hit = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (vec[i]) begin
            hit = 1'b1;
            idx = W'(i);
         end
      end
   end
endmodule // prio_pick

// ---- hdl/pic_cascade.sv ----
// cascaded priority interrupt controller: bus port, cascade bus, role pin
// assumes host strobes and acknowledge are synchronous to clock, active low

// Behaviour
// - master plus eight slaves gives 64 levels
// - master selects slave via three-line cascade bus
// - slave drives vector in acknowledge bytes two/three
// - cascade low idle, code from ack1 to ack3
// - master drives cascade for every acknowledged input when not in single mode
// - read/write need select; acknowledge does not
// - select bit high: mask register write/read
// - select bit low: mode write, status read
// - edge mode latches rising request edge
// - level mode latches high request level
// - interrupt output flags pending serviceable request
// - cascade lines output in master, input slave
// - master sends level code; slave compares identity
// - buffered mode pin enables bus transceivers
// - unbuffered pin input: high master, low slave
// - data bus carries programming, status, vectors
// - third init byte is slave map or identity
module pic_cascade (
   input wire logic clock,
   input wire logic rstn,
   input wire pic_pkg::host_bus_type host,
   input wire logic [7:0] request_inputs,
   input wire logic [2:0] cascade_in,
   input wire logic role_pin_in,
   output logic [2:0] cascade_out,
   output logic [2:0] cascade_oe_n,
   output logic role_pin_out,
   output logic role_pin_oe_n,
   output logic [7:0] data_out,
   output logic data_oe_n,
   output logic interrupt_out
);
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [7:0] request_register;
   logic [7:0] pend;
   logic pick_hit;
   logic [2:0] pick_idx;

   typedef struct packed {
      pic_pkg::init_state_type init;
      pic_pkg::config_type cfg;
      logic [7:0] mask_register;
      logic [7:0] in_service;
      logic read_is;
      logic rd_n_prev;
      logic wr_n_prev;
      logic ack_n_prev;
      logic [1:0] ack_count;
      logic [2:0] level;
      logic [2:0] cascade_out;
      logic cascade_drive;
      logic respond;
      logic [7:0] data_out;
      logic data_drive;
      logic irq;
   } state_type;
   state_type s_q, s_d;
   logic [7:0] clear_req;

   // reset released through two flops
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) rst_sync_q <= 2'b00;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   req_latch #(.N(pic_pkg::NUM_LEVELS)) u_req (
      .clock(clock),
      .rst_n(rst_n),
      .level_mode(s_q.cfg.level_mode),
      .request_inputs(request_inputs),
      .clear(clear_req),
      .init_clear(s_q.init == pic_pkg::INIT_VEC),
      .request_register(request_register)
   );

   assign pend = request_register & ~s_q.mask_register;

   prio_pick #(.N(8), .W(3)) u_pick (
      .vec(pend),
      .hit(pick_hit),
      .idx(pick_idx)
   );

   // role: pin sets master in unbuffered mode, config bit in buffered
   logic is_master;
   assign is_master = s_q.cfg.buffered ? s_q.cfg.buf_master : role_pin_in;
   // slave in single mode never exists; single forces master
   logic master_eff;
   assign master_eff = is_master | s_q.cfg.single;
   logic has_slave;
   assign has_slave = master_eff && !s_q.cfg.single && s_q.cfg.third_init_byte[s_q.level];
   // a slave answers only when the broadcast code matches its identity
   logic id_match;
   assign id_match = (cascade_in == s_q.cfg.third_init_byte[2:0]);

   // strobe edges
   logic wr_done, rd_start, rd_end, ack_start, ack_end;
   assign wr_done = !s_q.wr_n_prev ? (host.wr_n && !host.cs_n) : 1'b0;
   assign rd_start = s_q.rd_n_prev && !host.rd_n && !host.cs_n;
   assign rd_end = !s_q.rd_n_prev && host.rd_n;
   assign ack_start = s_q.ack_n_prev && !host.ack_n;
   assign ack_end = !s_q.ack_n_prev && host.ack_n;

   // main next-state logic
   always_comb begin
      logic [7:0] d;
      logic [2:0] lvl;
      d = host.wdata;
      lvl = d[2:0];
      s_d = s_q;
      clear_req = '0;
      s_d.rd_n_prev = host.rd_n;
      s_d.wr_n_prev = host.wr_n;
      s_d.ack_n_prev = host.ack_n;
      // writes: init sequence, mask, commands
      if (wr_done) begin
         if (!host.register_select_bit && d[pic_pkg::INIT_FLAG_BIT]) begin
            s_d.init = pic_pkg::INIT_VEC;
            s_d.cfg = '0;
            s_d.cfg.level_mode = d[pic_pkg::LEVEL_MODE_BIT];
            s_d.cfg.single = d[pic_pkg::SINGLE_BIT];
            s_d.cfg.need_fourth = d[pic_pkg::NEED_FOURTH_BIT];
            s_d.mask_register = pic_pkg::MASK_RESET;
            s_d.in_service = '0;
            s_d.read_is = 1'b0;
         end else if (host.register_select_bit) begin
            case (s_q.init)
               pic_pkg::INIT_VEC: begin
                  s_d.cfg.vec_base = d[7:3];
                  if (!s_q.cfg.single) s_d.init = pic_pkg::INIT_CAS;
                  else if (s_q.cfg.need_fourth) s_d.init = pic_pkg::INIT_MODE;
                  else s_d.init = pic_pkg::INIT_IDLE;
               end
               pic_pkg::INIT_CAS: begin
                  s_d.cfg.third_init_byte = d;
                  s_d.init = s_q.cfg.need_fourth ? pic_pkg::INIT_MODE : pic_pkg::INIT_IDLE;
               end
               pic_pkg::INIT_MODE: begin
                  s_d.cfg.wide_cpu = d[pic_pkg::WIDE_CPU_BIT];
                  s_d.cfg.auto_eoi = d[pic_pkg::AUTO_EOI_BIT];
                  s_d.cfg.buf_master = d[pic_pkg::BUF_MASTER_BIT];
                  s_d.cfg.buffered = d[pic_pkg::BUFFERED_BIT];
                  s_d.init = pic_pkg::INIT_IDLE;
               end
               default: s_d.mask_register = d;
            endcase
         end else if (d[pic_pkg::CMD3_BIT]) begin
            if (d[pic_pkg::READ_SEL_EN_BIT]) s_d.read_is = d[pic_pkg::READ_SEL_IS_BIT];
         end else if (d[pic_pkg::EOI_BIT]) begin
            // end of service: specific level or highest in service
            if (d[pic_pkg::SPECIFIC_BIT]) s_d.in_service[lvl] = 1'b0;
            else begin
               for (int i = 7; i >= 0; i--) begin
                  if (s_q.in_service[i]) lvl = 3'(i);
               end
               s_d.in_service[lvl] = 1'b0;
            end
         end
      end
      // register reads drive the data bus
      if (rd_start) begin
         s_d.data_drive = 1'b1;
         if (host.register_select_bit) s_d.data_out = s_q.mask_register;
         else s_d.data_out = s_q.read_is ? s_q.in_service : request_register;
      end
      if (rd_end) s_d.data_drive = 1'b0;
      // acknowledge sequence
      if (ack_start) begin
         if (s_q.ack_count == 2'd0) begin
            s_d.level = pick_idx;
            if (master_eff || !pick_hit) begin
               s_d.respond = 1'b1;
            end else begin
               s_d.respond = 1'b0;
            end
            if (!master_eff) s_d.respond = id_match;
            if (pick_hit && !s_q.cfg.auto_eoi) s_d.in_service[pick_idx] = 1'b1;
            clear_req[pick_idx] = pick_hit;
            s_d.data_drive = ~s_q.cfg.wide_cpu & master_eff & ~(s_q.cfg.third_init_byte[pick_idx]
                             & ~s_q.cfg.single);
            s_d.data_out = pic_pkg::CALL_OPCODE;
         end else begin
            if (!master_eff) s_d.respond = id_match;
            // vector bytes from the addressed slave or a master with no slave
            s_d.data_drive = s_d.respond && !has_slave;
            if (s_q.cfg.wide_cpu) s_d.data_out = {s_q.cfg.vec_base, s_q.level};
            else if (s_q.ack_count == 2'd1) s_d.data_out = {s_q.level, 5'b0_0000};
            else s_d.data_out = {3'b000, s_q.cfg.vec_base};
         end
      end
      if (ack_end) begin
         s_d.data_drive = 1'b0;
         if (s_q.ack_count == 2'd0) begin
            s_d.ack_count = 2'd1;
            s_d.cascade_drive = master_eff && !s_q.cfg.single;
            s_d.cascade_out = s_q.level;
            if (s_q.cfg.wide_cpu) s_d.cascade_out = s_q.level;
         end else if (s_q.ack_count == 2'd2 || s_q.cfg.wide_cpu) begin
            s_d.ack_count = 2'd0;
            s_d.cascade_drive = 1'b0;
            s_d.cascade_out = 3'b000;
         end else begin
            s_d.ack_count = 2'd2;
         end
      end
      // interrupt output raised for an unmasked request above any in service
      s_d.irq = pick_hit && ((s_q.in_service & ((8'(1) << pick_idx) | ((8'(1) << pick_idx) - 8'(1))))
                == 8'h00_00) && s_q.init == pic_pkg::INIT_IDLE;
      if (s_q.ack_count != 2'd0 || ack_start) s_d.irq = 1'b0;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.rd_n_prev <= 1'b1;
         s_q.wr_n_prev <= 1'b1;
         s_q.ack_n_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops; transceiver enable follows data drive
   assign cascade_out = s_q.cascade_out;
   assign cascade_oe_n = {3{~s_q.cascade_drive}};
   assign role_pin_out = ~s_q.data_drive;
   assign role_pin_oe_n = ~s_q.cfg.buffered;
   assign data_out = s_q.data_out;
   assign data_oe_n = ~s_q.data_drive;
   assign interrupt_out = s_q.irq;

   // assertions
   cas_idle_low_a: assert property (@(posedge clock) disable iff (!rst_n)
      (s_q.ack_count == 2'd0) |-> (cascade_out == 3'b000 && cascade_oe_n == 3'b111))
      else $error("cascade not idle low");
   cas_after_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
      (ack_end && s_q.ack_count == 2'd0 && master_eff && !s_q.cfg.single)
      |=> (cascade_oe_n == 3'b000 && cascade_out == $past(s_q.level)))
      else $error("master did not drive cascade");
   slave_no_cas_a: assert property (@(posedge clock) disable iff (!rst_n)
      (s_q.cfg.buffered && !s_q.cfg.buf_master && !s_q.cfg.single) |-> cascade_oe_n == 3'b111)
      else $error("slave drives cascade");
   // without select or acknowledge nothing may start driving the data bus
   rd_needs_cs_a: assert property (@(posedge clock) disable iff (!rst_n)
      (host.cs_n && host.ack_n && data_oe_n) |=> data_oe_n)
      else $error("read without select");
   mask_write_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_done && host.register_select_bit && s_q.init == pic_pkg::INIT_IDLE)
      |=> s_q.mask_register == $past(host.wdata))
      else $error("mask not loaded");
   mask_read_a: assert property (@(posedge clock) disable iff (!rst_n)
      (rd_start && host.register_select_bit) |=> (data_out == $past(s_q.mask_register)
      && data_oe_n == 1'b0)) else $error("mask not read");
   status_read_a: assert property (@(posedge clock) disable iff (!rst_n)
      (rd_start && !host.register_select_bit && !s_q.read_is)
      |=> data_out == $past(request_register)) else $error("status read wrong");
   irq_masked_a: assert property (@(posedge clock) disable iff (!rst_n)
      (pend == 8'h00_00) |=> !interrupt_out) else $error("irq with nothing pending");
   buf_enable_a: assert property (@(posedge clock) disable iff (!rst_n)
      s_q.cfg.buffered |-> (role_pin_oe_n == 1'b0 && role_pin_out == data_oe_n))
      else $error("transceiver enable wrong");
   unbuf_input_a: assert property (@(posedge clock) disable iff (!rst_n)
      !s_q.cfg.buffered |-> role_pin_oe_n) else $error("role pin driven");
   // acknowledge sequence guards
   irq_in_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
      (s_q.ack_count != 2'd0) |=> !interrupt_out)
      else $error("irq raised during acknowledge");
   slave_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
      (ack_start && s_q.ack_count != 2'd0 && !master_eff && !id_match) |=> data_oe_n)
      else $error("unaddressed slave drove vector");
   vec_byte_a: assert property (@(posedge clock) disable iff (!rst_n)
      (ack_start && s_q.ack_count == 2'd2 && master_eff && !s_q.cfg.wide_cpu)
      |=> data_out == {3'b000, $past(s_q.cfg.vec_base)}) else $error("third byte wrong");
   cas_release_a: assert property (@(posedge clock) disable iff (!rst_n)
      (ack_end && s_q.ack_count == 2'd2) |=> cascade_oe_n == 3'b111)
      else $error("cascade held after last pulse");
   // the data bus lets go as soon as its strobe ends
   data_release_a: assert property (@(posedge clock) disable iff (!rst_n)
      (ack_end || (rd_end && !ack_start)) |=> data_oe_n)
      else $error("data bus held after strobe");

   cov_three_ack_c: cover property (@(posedge clock) disable iff (!rst_n)
      ack_end && s_q.ack_count == 2'd2);
   cov_master_cas_c: cover property (@(posedge clock) disable iff (!rst_n)
      cascade_oe_n == 3'b000);
   cov_slave_vec_c: cover property (@(posedge clock) disable iff (!rst_n)
      !master_eff && !data_oe_n && s_q.ack_count != 2'd0);
   cov_irq_c: cover property (@(posedge clock) disable iff (!rst_n) $rose(interrupt_out));
   // in-service status read selected and taken
   cov_is_read_c: cover property (@(posedge clock) disable iff (!rst_n)
      rd_start && s_q.read_is);
endmodule // pic_cascade

// ---- dv/cascade_peer.sv ----
// far-side model of the cascade bus: stands in for the other controllers
// assumes ack_n comes from the bench and is synchronous to clock
module cascade_peer (
   input wire logic clock,
   input wire logic rstn,
   input wire logic ack_n,
   input wire logic wide,
   input wire logic [2:0] code,
   input wire logic [2:0] cascade_out,
   input wire logic [2:0] cascade_oe_n,
   output logic [2:0] cascade_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic ack_q;
   logic [1:0] rises_q;

   // count acknowledge rises; the window closes at the last pulse of the cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b1;
         rises_q <= 2'd0;
      end else begin
         ack_q <= ack_n;
         if (ack_n && !ack_q) begin
            rises_q <= (rises_q == (wide ? 2'd1 : 2'd2)) ? 2'd0 : rises_q + 2'd1;
         end
      end
   end

   // wire level: the device when it drives, else a peer master code, else low idle
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (!cascade_oe_n[i]) begin
            cascade_in[i] = cascade_out[i];
         end else begin
            cascade_in[i] = (rises_q != 2'd0) ? code[i] : 1'b0;
         end
      end
   end
endmodule // cascade_peer

// ---- dv/irq_ctrl_cascade_bus_port_tb.sv ----
// bench for the cascaded interrupt controller: master then buffered slave
// assumes the design and cascade_peer are compiled first
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module irq_ctrl_cascade_bus_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rstn, role_ext, role_pin_in, role_pin_out, role_pin_oe_n;
   logic data_oe_n, interrupt_out, wide, doe, rp;
   pic_pkg::host_bus_type host;
   logic [7:0] request_inputs, data_out, d;
   logic [2:0] cascade_in, cascade_out, cascade_oe_n, peer_code, coe, cv;
   int error_cnt, n_checks;

   // role pin wire level from both drivers
   assign role_pin_in = role_pin_oe_n ? role_ext : role_pin_out;

   pic_cascade uut (.clock(clock), .rstn(rstn), .host(host), .request_inputs(request_inputs),
      .cascade_in(cascade_in), .role_pin_in(role_pin_in), .cascade_out(cascade_out),
      .cascade_oe_n(cascade_oe_n), .role_pin_out(role_pin_out), .role_pin_oe_n(role_pin_oe_n),
      .data_out(data_out), .data_oe_n(data_oe_n), .interrupt_out(interrupt_out));

   cascade_peer peer (.clock(clock), .rstn(rstn), .ack_n(host.ack_n), .wide(wide),
      .code(peer_code), .cascade_out(cascade_out), .cascade_oe_n(cascade_oe_n),
      .cascade_in(cascade_in));

   // clock at 100 ns period
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // write strobe, taken when wr_n returns high with select still low
   task automatic wr(input logic cs_n, input logic sel, input logic [7:0] dat);
      @(negedge clock);
      host.cs_n = cs_n;
      host.wr_n = 1'b0;
      host.register_select_bit = sel;
      host.wdata = dat;
      @(negedge clock);
      host.wr_n = 1'b1;
      @(negedge clock);
      host.cs_n = 1'b1;
      @(negedge clock);
   endtask

   // read strobe, answer sampled while rd_n is still low
   task automatic rd(input logic cs_n, input logic sel);
      @(negedge clock);
      host.cs_n = cs_n;
      host.rd_n = 1'b0;
      host.register_select_bit = sel;
      repeat (2) @(negedge clock);
      d = data_out;
      doe = data_oe_n;
      host.rd_n = 1'b1;
      host.cs_n = 1'b1;
      repeat (2) @(negedge clock);
   endtask

   // one acknowledge pulse, select left high on purpose
   task automatic ack();
      @(negedge clock);
      host.ack_n = 1'b0;
      repeat (2) @(negedge clock);
      d = data_out;
      doe = data_oe_n;
      rp = role_pin_out;
      @(negedge clock);
      host.ack_n = 1'b1;
      repeat (2) @(negedge clock);
      coe = cascade_oe_n;
      cv = cascade_out;
   endtask

   // verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // watchdog well past the expected run length
   initial begin
      #(5000 * 100);
      error_cnt++;
      $display("watchdog expired");
      conclude();
   end

   // main sequence
   initial begin
      host = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ack_n: 1'b1, register_select_bit: 1'b0,
         wdata: 8'h00_00};
      rstn = 1'b0;
      request_inputs = 8'h00_00;
      role_ext = 1'b1;
      wide = 1'b0;
      peer_code = 3'd0;
      error_cnt = 0;
      n_checks = 0;
      repeat (12) @(negedge clock);
      rstn = 1'b1;
      repeat (4) @(negedge clock);
      `CHK("cascade idle", 3'b111, cascade_oe_n)
      `CHK("bus idle", 1'b1, data_oe_n)
      `CHK("irq idle", 1'b0, interrupt_out)
      `CHK("role pin input", 1'b1, role_pin_oe_n)
      $display("test reset done");
      // master: edge, cascaded, fourth byte; slaves on inputs one to seven
      wr(1'b0, 1'b0, 8'h00_11);
      wr(1'b0, 1'b1, 8'h00_40);
      wr(1'b0, 1'b1, 8'h00_FE);
      wr(1'b0, 1'b1, 8'h00_00);
      wr(1'b0, 1'b1, 8'h00_A5);
      wr(1'b1, 1'b1, 8'h00_FF);
      rd(1'b0, 1'b1);
      `CHK("mask read", 8'h00_A5, d)
      `CHK("mask drive", 1'b0, doe)
      rd(1'b1, 1'b1);
      `CHK("read unselected", 1'b1, doe)
      wr(1'b0, 1'b1, 8'h00_00);
      wr(1'b0, 1'b0, 8'h00_0A);
      request_inputs = 8'h00_09;
      repeat (4) @(negedge clock);
      `CHK("irq pending", 1'b1, interrupt_out)
      rd(1'b0, 1'b0);
      `CHK("request status", 8'h00_09, d)
      $display("test master registers done");
      // level zero has no slave: master supplies all three bytes
      ack();
      `CHK("byte1", pic_pkg::CALL_OPCODE, d)
      `CHK("cascade on", 3'b000, coe)
      `CHK("cascade code0", 3'd0, cv)
      `CHK("irq blocked", 1'b0, interrupt_out)
      ack();
      `CHK("byte2", 8'h00_00, d)
      `CHK("cascade held", 3'b000, coe)
      ack();
      `CHK("byte3", 8'h00_08, d)
      `CHK("cascade off", 3'b111, coe)
      wr(1'b0, 1'b0, 8'h00_20);
      repeat (4) @(negedge clock);
      `CHK("irq next", 1'b1, interrupt_out)
      // level three has a slave: the slave supplies bytes two and three
      ack();
      `CHK("cascade code3", 3'd3, cv)
      `CHK("cascade on3", 3'b000, coe)
      ack();
      `CHK("master quiet", 1'b1, doe)
      ack();
      `CHK("cascade off3", 3'b111, coe)
      wr(1'b0, 1'b0, 8'h00_0B);
      rd(1'b0, 1'b0);
      `CHK("in service", 8'h00_08, d)
      request_inputs = 8'h00_00;
      wr(1'b0, 1'b0, 8'h00_63);
      rd(1'b0, 1'b0);
      `CHK("in service cleared", 8'h00_00, d)
      $display("test master acknowledge done");
      // slave: level, wide cpu, buffered, identity five, level two held high
      role_ext = 1'b0;
      wide = 1'b1;
      request_inputs = 8'h00_04;
      wr(1'b0, 1'b0, 8'h00_19);
      wr(1'b0, 1'b1, 8'h00_A8);
      wr(1'b0, 1'b1, 8'h00_05);
      wr(1'b0, 1'b1, 8'h00_09);
      repeat (4) @(negedge clock);
      `CHK("enable output", 1'b0, role_pin_oe_n)
      `CHK("enable idle", 1'b1, role_pin_out)
      `CHK("level irq", 1'b1, interrupt_out)
      for (int i = 0; i < 2; i++) begin
         peer_code = (i == 0) ? 3'd5 : 3'd2;
         ack();
         `CHK("slave cascade input", 3'b111, coe)
         ack();
         if (i == 0) begin
            `CHK("wide vector", 8'h00_AA, d)
         end
         `CHK("slave drive", (i != 0), doe)
         `CHK("enable pin", (i != 0), rp)
         wr(1'b0, 1'b0, 8'h00_20);
      end
      $display("test slave done");
      conclude();
   end
endmodule // irq_ctrl_cascade_bus_port_tb
